// file: hdl/swec_core.sv
// Status word, saved words and exception entry and return sequencing
`timescale 1ns/1ps
module swec_core
    import swec_pkg::*;
(
    // Clock, reset and enable
    input  wire logic               clk_sys,
    input  wire logic               reset,
    input  wire logic               clkEn,
    // Wishbone slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [3:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    // Pipeline side
    input  wire logic               instrEnd,
    input  wire logic [31:0]        pcCurrent,
    input  wire swec_flags_t        aluFlags,
    input  wire logic [3:0]         condCode,
    input  wire logic               isBranch,
    input  wire swec_exc_t          excReq,
    input  wire logic               excReturn,
    output logic                    condPass,
    output logic                    fetchLoad,
    output logic      [31:0]        fetchAddr,
    output logic      [31:0]        linkValue,
    output logic                    linkWrite,
    output logic                    bankFiqHigh,
    output logic      [2:0]         bankSelect,
    output logic                    privileged,
    // Pins
    input  wire logic               fast_int_req_n,
    input  wire logic               normal_int_req_n,
    output logic                    state_output_pin,
    output logic      [31:0]        current_status_word
);

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    // Saved-word bank for a mode code
    // User and system share the plain set, so both map to no bank
    // Undefined codes also map to no bank and leave banking untouched
    function automatic logic [2:0] bankOf(input logic [4:0] m);
        case (m)
            MODE_FIQ: bankOf = BANK_FIQ;
            MODE_IRQ: bankOf = BANK_IRQ;
            MODE_SVC: bankOf = BANK_SVC;
            MODE_ABT: bankOf = BANK_ABT;
            MODE_UND: bankOf = BANK_UND;
            default:  bankOf = BANK_NONE;
        endcase
    endfunction : bankOf

    // Condition code test against flags
    // Upper three bits pick the test, bit 0 inverts it
    // Test seven (codes 14 and 15) is always true and is never inverted
    function automatic logic condTest(input logic [3:0] cc, input swec_status_t s);
        logic r;
        r = 1'b0;
        case (cc[3:1])
            3'h0: r = s.z;
            3'h1: r = s.c;
            3'h2: r = s.n;
            3'h3: r = s.v;
            3'h4: r = s.c & ~s.z;
            3'h5: r = (s.n == s.v);
            3'h6: r = ~s.z & (s.n == s.v);
            default: r = 1'b1;
        endcase
        if (cc[0] && cc[3:1] != 3'h7) begin
            r = ~r;
        end
        condTest = r;
    endfunction : condTest

    ////////////////////////////////////////////////////////////////////////////
    // State

    // Registered state; saved words and links carry no reset
    swec_status_t status_q;
    logic [31:0]  saved_q [0:4];
    logic [31:0]  linkReg_q [0:4];
    // Request line synchronizers
    logic         fiqSync1_q;
    logic         fiqSync2_q;
    logic         irqSync1_q;
    logic         irqSync2_q;
    // Bus slave registers and sequencer
    logic         ack_q;
    logic [31:0]  rdData_q;
    swec_state_t  state_q;

    // Combinational decode of the current cycle
    logic [2:0]   curBank;
    logic         wbReq;
    logic         fiqTake;
    logic         irqTake;
    logic         excTake;
    logic [4:0]   newMode;
    logic [31:0]  newVector;
    logic [31:0]  newLink;
    logic         setI;
    logic         setF;

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode and banking

    // Bank follows mode combinationally
    // No register stage, so a mode change banks the very next access
    assign curBank     = bankOf(status_q.mode);
    assign bankSelect  = curBank;
    assign bankFiqHigh = (status_q.mode == MODE_FIQ);
    assign privileged  = (status_q.mode != MODE_USR);

    // Condition evaluation depends on the state bit
    // Compact state runs all but branches unconditionally
    assign condPass = (status_q.state && !isBranch) ? 1'b1
                                                    : condTest(condCode, status_q);

    // State bit and word on pins
    // Both come straight from the register, never from decode
    assign state_output_pin    = status_q.state;
    assign current_status_word = status_q;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt synchronizers

    // Two-stage sync of the request lines
    // Reset loads the idle high level, so no false request follows reset
    // Only the second stage is read anywhere else
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fiqSync1_q <= 1'b1;
            fiqSync2_q <= 1'b1;
            irqSync1_q <= 1'b1;
            irqSync2_q <= 1'b1;
        end else if (clkEn) begin
            fiqSync1_q <= fast_int_req_n;
            fiqSync2_q <= fiqSync1_q;
            irqSync1_q <= normal_int_req_n;
            irqSync2_q <= irqSync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Exception selection

    // Masked requests sampled at instruction end
    // A request is looked at only on an instruction end
    // Low level must reach the second stage before that end
    assign fiqTake = instrEnd && !fiqSync2_q && !status_q.maskF;
    assign irqTake = instrEnd && !irqSync2_q && !status_q.maskI;

    // Any cause is taken only while the sequencer runs
    assign excTake = (state_q == ST_RUN) && (fiqTake || irqTake ||
                     (instrEnd && (|excReq)));

    // Fixed priority: data abort, fast, normal, prefetch, trap
    // Defaults give the undefined trap, the lowest cause
    // Data abort and traps override the plain four-byte link
    always_comb begin
        newMode   = MODE_UND;
        newVector = VEC_UND;
        newLink   = pcCurrent + OFS_4;
        setI      = 1'b0;
        setF      = 1'b0;
        if (instrEnd && excReq.dataAbort) begin
            newMode   = MODE_ABT;
            newVector = VEC_DAB;
            newLink   = pcCurrent + OFS_8;
        end else if (fiqTake) begin
            newMode   = MODE_FIQ;
            newVector = VEC_FIQ;
            // Fast entry masks both request lines
            setI      = 1'b1;
            setF      = 1'b1;
        end else if (irqTake) begin
            newMode   = MODE_IRQ;
            newVector = VEC_IRQ;
            // Normal entry masks only the normal line
            setI      = 1'b1;
        end else if (excReq.prefetchAbort) begin
            newMode   = MODE_ABT;
            newVector = VEC_PAB;
        end else if (excReq.softwareTrap) begin
            newMode   = MODE_SVC;
            newVector = VEC_SWT;
            // Trap link follows the state it left
            setI      = 1'b1;
            newLink   = pcCurrent + (status_q.state ? OFS_2 : OFS_4);
        end else begin
            newLink   = pcCurrent + (status_q.state ? OFS_2 : OFS_4);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    // Reset vectoring then run; entry takes one cycle
    // The enter state blocks a second entry in the next cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= ST_RESET;
        end else if (clkEn) begin
            case (state_q)
                ST_RESET: state_q <= ST_RUN;
                ST_RUN:   state_q <= excTake ? ST_ENTER : ST_RUN;
                ST_ENTER: state_q <= ST_RUN;
                default:  state_q <= ST_RESET;
            endcase
        end
    end

    // Fetch redirect pulse
    // Address holds between pulses for the fetch unit
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fetchLoad <= 1'b0;
            fetchAddr <= VEC_RST;
        end else if (clkEn) begin
            fetchLoad <= 1'b0;
            if (state_q == ST_RESET) begin
                fetchLoad <= 1'b1;
                fetchAddr <= VEC_RST;
            end else if (excTake) begin
                fetchLoad <= 1'b1;
                fetchAddr <= newVector;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Current status word

    // Reset, entry, return, software and flag updates
    // Entry wins over return, return over software, software over flags
    // Entry touches only the control byte; flags stay as they were
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            status_q <= STATUS_RESET;
        end else if (clkEn) begin
            if (excTake) begin
                status_q.mode  <= newMode;
                // Handlers always start in the wide state
                status_q.state <= 1'b0;
                if (setI) begin
                    status_q.maskI <= 1'b1;
                end
                if (setF) begin
                    status_q.maskF <= 1'b1;
                end
            end else if (excReturn && curBank != BANK_NONE) begin
                // Brings back the state bit held before entry
                status_q <= saved_q[curBank];
            end else if (wbReq && wb_we_i && wb_adr_i == ADDR_STATUS) begin
                // Flags lane open to all; control lane only when privileged
                if (wb_sel_i[3]) begin
                    status_q[31:24] <= wb_dat_i[31:24];
                end
                if (wb_sel_i[0] && privileged) begin
                    status_q[7:0] <= wb_dat_i[7:0];
                end
            end else if (aluFlags.valid) begin
                {status_q.n, status_q.z, status_q.c, status_q.v} <= aluFlags.nzcv;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Saved words and banked link registers

    // Entry copies the word; software writes in privileged modes
    // Writes in user or system mode have no bank and are dropped
    always_ff @(posedge clk_sys) begin
        if (clkEn) begin
            if (excTake) begin
                saved_q[bankOf(newMode)] <= status_q;
            end else if (wbReq && wb_we_i && wb_adr_i == ADDR_SAVED
                         && curBank != BANK_NONE) begin
                saved_q[curBank] <= wb_dat_i;
            end
        end
    end

    // Link register not reset, left undefined
    // Software must not trust a link value before the first entry
    always_ff @(posedge clk_sys) begin
        if (clkEn && excTake) begin
            linkReg_q[bankOf(newMode)] <= newLink;
        end
    end

    // Link write pulse toward the register file
    // Same value reaches the register file in the cycle the entry mode and vector load appear
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            linkWrite <= 1'b0;
            linkValue <= 32'h0000_0000;
        end else if (clkEn) begin
            linkWrite <= excTake;
            if (excTake) begin
                linkValue <= newLink;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave

    // Request taken only while ack is low, so one ack per cycle
    assign wbReq    = wb_cyc_i && wb_stb_i && !ack_q && clkEn;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdData_q;

    // One-cycle ack and registered read data
    // Read data captured on the request edge, held until the next read
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ack_q    <= 1'b0;
            rdData_q <= 32'h0000_0000;
        end else if (clkEn) begin
            ack_q <= wbReq;
            if (wbReq && !wb_we_i) begin
                case (wb_adr_i)
                    ADDR_STATUS: rdData_q <= status_q;
                    ADDR_SAVED:  rdData_q <= (curBank == BANK_NONE) ? status_q
                                                                    : saved_q[curBank];
                    ADDR_LINK:   rdData_q <= (curBank == BANK_NONE) ? 32'h0000_0000
                                                                    : linkReg_q[curBank];
                    // Info word: sequencer state, bank, privilege, fast sync
                    ADDR_INFO:   rdData_q <= {24'h00_0000, state_q, curBank, privileged,
                                              fiqSync2_q};
                    default:     rdData_q <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule : swec_core

// file: shared/swec_pkg.sv
// Constants, types and layout of the status word and exception controller
//
// Summary of operation
// - Flags N Z C V in bits 31..28
// - Flags set by ALU and status write
// - Condition check: all wide, branch-only compact
// - Exceptions alter the low control byte
// - Control bits writable only when privileged
// - State bit 5, driven on state pin
// - Mask bits 7 and 6 block interrupts
// - Seven mode codes decoded
// - Banking of registers and saved words by mode
// - Link value per exception and state
// - Entry saves word, sets mode, vectors
// - Entry may set interrupt masks
// - Exceptions always run in wide state
// - Return restores the state bit
// - Fast request low sampled per instruction end
// - Normal request lower priority, masked on fast
// - Supervisor link undefined after reset
// - Vector addresses and entry mask settings
// - Fixed exception priority order
// - Reset: supervisor, masks set, wide, address 0
package swec_pkg;

    // Status word field positions
    localparam int FLAG_N_BIT   = 31;
    localparam int FLAG_Z_BIT   = 30;
    localparam int FLAG_C_BIT   = 29;
    localparam int FLAG_V_BIT   = 28;
    localparam int MASK_I_BIT   = 7;
    localparam int MASK_F_BIT   = 6;
    localparam int STATE_BIT    = 5;

    // Mode codes
    localparam logic [4:0] MODE_USR = 5'h10;
    localparam logic [4:0] MODE_FIQ = 5'h11;
    localparam logic [4:0] MODE_IRQ = 5'h12;
    localparam logic [4:0] MODE_SVC = 5'h13;
    localparam logic [4:0] MODE_ABT = 5'h17;
    localparam logic [4:0] MODE_UND = 5'h1b;
    localparam logic [4:0] MODE_SYS = 5'h1f;

    // Vectors
    localparam logic [31:0] VEC_RST = 32'h0000_0000;
    localparam logic [31:0] VEC_UND = 32'h0000_0004;
    localparam logic [31:0] VEC_SWT = 32'h0000_0008;
    localparam logic [31:0] VEC_PAB = 32'h0000_000c;
    localparam logic [31:0] VEC_DAB = 32'h0000_0010;
    localparam logic [31:0] VEC_IRQ = 32'h0000_0018;
    localparam logic [31:0] VEC_FIQ = 32'h0000_001c;

    // Link offsets
    localparam logic [31:0] OFS_2 = 32'h0000_0002;
    localparam logic [31:0] OFS_4 = 32'h0000_0004;
    localparam logic [31:0] OFS_8 = 32'h0000_0008;

    // Reset value of the current status word: supervisor, both masks, wide
    localparam logic [31:0] STATUS_RESET = 32'h0000_00d3;

    // Saved word bank indices
    localparam logic [2:0] BANK_FIQ  = 3'h0;
    localparam logic [2:0] BANK_IRQ  = 3'h1;
    localparam logic [2:0] BANK_SVC  = 3'h2;
    localparam logic [2:0] BANK_ABT  = 3'h3;
    localparam logic [2:0] BANK_UND  = 3'h4;
    localparam logic [2:0] BANK_NONE = 3'h7;

    // Wishbone register offsets (byte addresses)
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_SAVED  = 4'h4;
    localparam logic [3:0] ADDR_LINK   = 4'h8;
    localparam logic [3:0] ADDR_INFO   = 4'hc;

    // Status word layout
    typedef struct packed {
        logic       n;
        logic       z;
        logic       c;
        logic       v;
        logic [19:0] rsvd;
        logic       maskI;
        logic       maskF;
        logic       state;
        logic [4:0] mode;
    } swec_status_t;

    // Condition flags from the ALU
    typedef struct packed {
        logic       valid;
        logic [3:0] nzcv;
    } swec_flags_t;

    // Exception requests sampled at instruction end
    typedef struct packed {
        logic dataAbort;
        logic prefetchAbort;
        logic undefinedTrap;
        logic softwareTrap;
    } swec_exc_t;

    // Entry sequencer states
    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_ENTER = 3'b010,
        ST_RESET = 3'b100
    } swec_state_t;

endpackage : swec_pkg

// file: sim/swec_assertions.sv
// Port checker of the status word and exception controller
`timescale 1ns/1ps
module swec_assertions
    import swec_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        instrEnd,
    input wire logic [31:0] pcCurrent,
    input wire swec_exc_t   excReq,
    input wire logic        fetchLoad,
    input wire logic [31:0] fetchAddr,
    input wire logic [31:0] linkValue,
    input wire logic        linkWrite,
    input wire logic        bankFiqHigh,
    input wire logic [2:0]  bankSelect,
    input wire logic        privileged,
    input wire logic        state_output_pin,
    input wire logic [31:0] current_status_word
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    wire logic [4:0] md = current_status_word[4:0];
    ////////////////////////////////////////////////////////////////
    // Data abort taken while the sequencer accepts, and its entry
    sequence s_dabReq;
        instrEnd && excReq.dataAbort && !fetchLoad && !$past(reset);
    endsequence
    sequence s_dabEntry;
        fetchLoad && linkWrite && fetchAddr == VEC_DAB && md == MODE_ABT;
    endsequence
    ////////////////////////////////////////////////////////////////
    a_state_pin: assert property (state_output_pin == current_status_word[5])
        else $error("state pin differs");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_entry_wide: assert property (fetchLoad |-> !current_status_word[5])
        else $error("entry not wide");
    a_priv_decode: assert property (privileged == (md != MODE_USR))
        else $error("privilege wrong");
    a_fiq_bank: assert property (bankFiqHigh == (md == MODE_FIQ))
        else $error("fast bank wrong");
    a_bank_select: assert property (bankSelect == (md == MODE_FIQ ? BANK_FIQ :
        md == MODE_IRQ ? BANK_IRQ : md == MODE_SVC ? BANK_SVC : md == MODE_ABT ? BANK_ABT :
        md == MODE_UND ? BANK_UND : BANK_NONE)) else $error("bank select wrong");
    a_fiq_masks: assert property (fetchLoad && fetchAddr == VEC_FIQ |->
        md == MODE_FIQ && current_status_word[7:6] == 2'b11) else $error("fast entry");
    a_reset_entry: assert property (fetchLoad && fetchAddr == VEC_RST |->
        md == MODE_SVC && current_status_word[7:5] == 3'b110) else $error("reset entry");
    a_dab_entry: assert property (s_dabReq |=> s_dabEntry)
        else $error("abort entry");
    a_dab_link: assert property (s_dabReq |=> linkValue == $past(pcCurrent) + OFS_8)
        else $error("abort link");
endmodule : swec_assertions

// file: sim/swec_irq_src.sv
// Interrupt request sources driving the active-low request pins
`timescale 1ns/1ps
module swec_irq_src (
    input  wire logic clk_sys,
    input  wire logic fastOn,
    input  wire logic normalOn,
    output logic      fast_int_req_n = 1'b1,
    output logic      normal_int_req_n = 1'b1
);
    // Low level held while the source wants service
    always @(posedge clk_sys) begin
        fast_int_req_n   <= ~fastOn;
        normal_int_req_n <= ~normalOn;
    end
endmodule : swec_irq_src

// file: sim/test_status_word_exception_control.sv
// Self-checking bench of the status word and exception controller
`timescale 1ns/1ps
module test_status_word_exception_control;
    import swec_pkg::*;
    logic        clk_sys = 1'b0, reset = 1'b1, cyc = 1'b0, we = 1'b0;
    logic [3:0]  adr = 4'h0, condCode = 4'h0;
    logic [31:0] wdat = 32'h0, pcCurrent = 32'h0;
    logic        instrEnd = 1'b0, excReturn = 1'b0, fastOn = 1'b0, normalOn = 1'b0;
    logic        isBranch = 1'b0, statePin;
    swec_flags_t aluFlags = '0;
    swec_exc_t   excReq = '0;
    logic        ack, condPass, fetchLoad, linkWrite, fiqN, irqN;
    logic [31:0] rdat, fetchAddr, linkValue, csw, lastLk;
    logic [31:0] rdQ[$];
    logic [64:0] exQ[$];
    int          err_count = 0, n_tests = 0, seed = 32'h63304993, i;
    logic [3:0]  cc[6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'he};
    logic        cx[6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

    initial forever #12.5 clk_sys = ~clk_sys;

    swec_irq_src u_src (.clk_sys, .fastOn, .normalOn,
        .fast_int_req_n(fiqN), .normal_int_req_n(irqN));
    swec_core u_dut (.clk_sys, .reset, .clkEn(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .instrEnd, .pcCurrent, .aluFlags, .condCode, .isBranch,
        .excReq, .excReturn, .condPass, .fetchLoad, .fetchAddr, .linkValue, .linkWrite,
        .bankFiqHigh(), .bankSelect(), .privileged(), .fast_int_req_n(fiqN),
        .normal_int_req_n(irqN), .state_output_pin(statePin), .current_status_word(csw));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("FAIL %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    // Classic single Wishbone cycle, bounded wait for ack
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 20);
        cyc <= 1'b0;
        if (ack !== 1'b1) begin
            err_count++;
            end_sim();
        end
    endtask : wb
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        rdQ.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask : rd
    // One instruction end carrying a request; note the entry if one is due
    task automatic exc(input swec_exc_t r, input logic [31:0] v, input logic [31:0] o,
                       input bit due);
        logic [31:0] pc;
        pc = $random(seed) & 32'hffff_fffc;
        if (due) exQ.push_back({1'b1, v, pc + o});
        lastLk = pc + o;
        @(posedge clk_sys);
        instrEnd <= 1'b1;
        excReq <= r;
        pcCurrent <= pc;
        @(posedge clk_sys);
        instrEnd <= 1'b0;
        excReq <= '0;
        repeat (3) @(posedge clk_sys);
    endtask : exc
    task automatic ret;
        @(posedge clk_sys);
        excReturn <= 1'b1;
        @(posedge clk_sys);
        excReturn <= 1'b0;
    endtask : ret
    ////////////////////////////////////////////////////////////////
    // Result watcher: read data and vector loads against the notes
    always @(posedge clk_sys) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (rdQ.size() == 0) chk("extra read", 32'h1, 32'h0);
            else chk("read data", rdat, rdQ.pop_front());
        end
        if (fetchLoad === 1'b1) begin
            if (exQ.size() == 0) chk("extra entry", 32'h1, 32'h0);
            else begin
                chk("vector", fetchAddr, exQ[0][63:32]);
                chk("link write", {31'h0, linkWrite}, {31'h0, exQ[0][64]});
                if (exQ[0][64]) chk("link", linkValue, exQ[0][31:0]);
                void'(exQ.pop_front());
            end
        end
    end
    // Main sequence
    initial begin
        exQ.push_back({1'b0, VEC_RST, 32'h0});
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        rd(ADDR_STATUS, STATUS_RESET);
        $display("test reset done");
        wb(1'b1, ADDR_STATUS, 32'hf000_00d3);
        rd(ADDR_STATUS, 32'hf000_00d3);
        aluFlags <= {1'b1, 4'h5};
        @(posedge clk_sys);
        aluFlags <= '0;
        rd(ADDR_STATUS, 32'h5000_00d3);
        for (i = 0; i < 6; i++) begin
            condCode <= cc[i];
            @(posedge clk_sys);
            chk("cond", {31'h0, condPass}, {31'h0, cx[i]});
        end
        $display("test flags done");
        wb(1'b1, ADDR_STATUS, 32'h5000_001f);
        exc(4'b0001, VEC_SWT, OFS_4, 1);
        rd(ADDR_STATUS, 32'h5000_0093);
        rd(ADDR_SAVED, 32'h5000_001f);
        ret();
        rd(ADDR_STATUS, 32'h5000_001f);
        exc(4'b0001, VEC_SWT, OFS_4, 1);
        wb(1'b1, ADDR_SAVED, 32'h5000_003f);
        ret();
        rd(ADDR_STATUS, 32'h5000_003f);
        chk("state pin", {31'h0, statePin}, 32'h1);
        chk("status word", csw, 32'h5000_003f);
        for (i = 0; i < 2; i++) begin
            condCode <= 4'h1;
            isBranch <= i[0];
            @(posedge clk_sys);
            chk("cond compact", {31'h0, condPass}, {31'h0, ~i[0]});
        end
        isBranch <= 1'b0;
        exc(4'b0001, VEC_SWT, OFS_2, 1);
        rd(ADDR_STATUS, 32'h5000_0093);
        rd(ADDR_SAVED, 32'h5000_003f);
        wb(1'b1, ADDR_SAVED, 32'h5000_001f);
        ret();
        rd(ADDR_STATUS, 32'h5000_001f);
        $display("test trap done");
        normalOn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        exc(4'h0, VEC_IRQ, OFS_4, 1);
        rd(ADDR_STATUS, 32'h5000_0092);
        ret();
        fastOn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        exc(4'h0, VEC_FIQ, OFS_4, 1);
        rd(ADDR_STATUS, 32'h5000_00d1);
        exc(4'h0, VEC_IRQ, OFS_4, 0);
        fastOn <= 1'b0;
        normalOn <= 1'b0;
        ret();
        $display("test interrupts done");
        wb(1'b1, ADDR_STATUS, 32'h0000_0010);
        wb(1'b1, ADDR_STATUS, 32'h0000_00df);
        rd(ADDR_STATUS, 32'h0000_0010);
        rd(ADDR_SAVED, 32'h0000_0010);
        rd(4'h2, 32'h0);
        exc(4'b0010, VEC_UND, OFS_4, 1);
        rd(ADDR_STATUS, 32'h0000_001b);
        exc(4'b0100, VEC_PAB, OFS_4, 1);
        normalOn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        exc(4'b1000, VEC_DAB, OFS_8, 1);
        rd(ADDR_STATUS, 32'h0000_0017);
        rd(ADDR_LINK, lastLk);
        rd(ADDR_INFO, {24'h00_0000, ST_RUN, BANK_ABT, 2'b11});
        $display("test user and aborts done");
        repeat (4) @(posedge clk_sys);
        end_sim();
    end
endmodule : test_status_word_exception_control

bind swec_core swec_assertions u_chk (.clk_sys, .reset, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .instrEnd, .pcCurrent, .excReq, .fetchLoad, .fetchAddr, .linkValue, .linkWrite,
    .bankFiqHigh, .bankSelect, .privileged, .state_output_pin, .current_status_word);
